/* hmag_pkg.sv */
// constants for the host memory address generator
package hmag_pkg;
   localparam int ADDR_W = 32;
   localparam int KIND_W = 4;
   localparam int CMD_W = 3;
   localparam int DEPTH = 2;
   // address request kinds
   localparam logic [3:0] KIND_CBL_START = 4'h0;
   localparam logic [3:0] KIND_RFA_START = 4'h1;
   localparam logic [3:0] KIND_NEXT_CB = 4'h2;
   localparam logic [3:0] KIND_TBD_ARRAY = 4'h3;
   localparam logic [3:0] KIND_NEXT_RFD = 4'h4;
   localparam logic [3:0] KIND_DUMP_BUF = 4'h5;
   localparam logic [3:0] KIND_TX_BUF = 4'h6;
   localparam logic [3:0] KIND_PORT_AREA = 4'h7;
   localparam logic [3:0] KIND_DUMP_CNT = 4'h8;
   // command unit control codes
   localparam logic [2:0] CU_NOP = 3'h0;
   localparam logic [2:0] CU_START = 3'h1;
   localparam logic [2:0] CU_RESUME = 3'h2;
   localparam logic [2:0] CU_LOAD_DUMP_ADDR = 3'h4;
   localparam logic [2:0] CU_LOAD_BASE = 3'h6;
   // receive unit control codes
   localparam logic [2:0] RU_NOP = 3'h0;
   localparam logic [2:0] RU_START = 3'h1;
   localparam logic [2:0] RU_LOAD_BASE = 3'h6;
   // reset values
   localparam logic [31:0] BASE_RESET = 32'h0000_0000;
   localparam logic [31:0] PTR_RESET = 32'h0000_0000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_ACCEPT = 2'b10,
      ST_ISSUE = 2'b11
   } hmag_state_e;
endpackage : hmag_pkg

/* hmag_addr_gen.sv */
// host memory address generator with control block command handling
`timescale 1ns/10ps

// Function
// [RL1] physical address is full 32-bit base plus full 32-bit offset
// [RL2] command unit base added to list start, links, descriptor arrays, dump buffers
// [RL3] receive unit base added to receive area start and descriptor links
// [RL4] transmit buffers, port area and dump counters pointer used as-is
// [RL5] linear mode: software loads both bases with zero
// [RL6] segmented mode: software keeps upper offset half at zero
// [RL7] software loads bases only while both units idle
// [RL8] software places self-test and dump areas on 16-byte boundaries
// [RL9] command blocks and descriptors start on even addresses
// [RL10] transmit data buffers may start at any byte address
// [RL11] receive data areas should be cache-line aligned under write-invalidate
// [RL12] every control block write makes the device read the whole block; the code ignores writes outside ST_IDLE
// [RL13] started command unit runs list, posts status, interrupts if configured
// [RL14] started receive unit becomes ready, posts status per frame, advances
// [RL15] software repeats initialization after software or selective reset
// [RL16] accepted command clears command low byte, then action follows
// [RL17] adder result is 32 bits, carry out discarded
module hmag_addr_gen (
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // control block write and fetched contents
   input wire logic SCB_WRITE,
   input wire logic SCB_FETCH_DONE,
   input wire logic [2:0] SCB_CU_CMD,
   input wire logic [2:0] SCB_RU_CMD,
   input wire logic [31:0] SCB_GEN_PTR,
   output logic SCB_FETCH,
   output logic SCB_CMD_CLEAR,
   // unit events
   input wire logic CU_LIST_DONE,
   input wire logic CU_IRQ_CFG,
   input wire logic RU_FRAME_DONE,
   output logic CU_STATUS_POST,
   output logic RU_STATUS_POST,
   output logic HOST_IRQ,
   output logic CU_ACTIVE,
   output logic RU_READY,
   output logic [31:0] DUMP_CNT_ADDR,
   // offset requests from the units
   input wire logic REQ_VALID,
   input wire logic [3:0] REQ_KIND,
   input wire logic [31:0] REQ_OFFSET,
   output logic REQ_READY,
   // physical address stream
   output logic ADDR_VALID,
   output logic [3:0] ADDR_KIND,
   output logic [31:0] ADDR_DATA,
   input wire logic ADDR_READY
);
   hmag_pkg::hmag_state_e state_reg, state_next;
   logic [31:0] cu_base_reg, cu_base_next;
   logic [31:0] ru_base_reg, ru_base_next;
   logic [31:0] gp_reg, gp_next;
   logic [2:0] cu_cmd_reg, cu_cmd_next;
   logic [2:0] ru_cmd_reg, ru_cmd_next;
   logic [31:0] dump_reg, dump_next;
   logic cu_act_reg, cu_act_next;
   logic ru_rdy_reg, ru_rdy_next;
   logic cu_post_reg, cu_post_next;
   logic ru_post_reg, ru_post_next;
   logic irq_reg, irq_next;
   logic cu_pend_reg, cu_pend_next;
   logic ru_pend_reg, ru_pend_next;

   // buffer state
   logic [35:0] mem_reg [0:1];
   logic [35:0] mem_next [0:1];
   logic wptr_reg, wptr_next;
   logic rptr_reg, rptr_next;
   logic [1:0] cnt_reg, cnt_next;

   logic buf_in_ready;
   logic push;
   logic pop;
   logic [3:0] push_kind;
   logic [31:0] push_off;
   logic [31:0] push_addr;
   logic scb_push;
   logic [3:0] scb_kind;
   logic [31:0] scb_off;

   // base selection and add
   function automatic logic [31:0] hmag_phys(input logic [3:0] kind,
                                             input logic [31:0] off,
                                             input logic [31:0] cu_b,
                                             input logic [31:0] ru_b);
      logic [32:0] sum;
      sum = 33'h0_0000_0000;
      unique case (kind)
         // [RL2] command unit based
         hmag_pkg::KIND_CBL_START, hmag_pkg::KIND_NEXT_CB,
         hmag_pkg::KIND_TBD_ARRAY, hmag_pkg::KIND_DUMP_BUF: begin
            // [RL1] full width add
            sum = {1'b0, cu_b} + {1'b0, off};
         end
         // [RL3] receive unit based
         hmag_pkg::KIND_RFA_START, hmag_pkg::KIND_NEXT_RFD: begin
            sum = {1'b0, ru_b} + {1'b0, off};
         end
         // [RL4] absolute, no base; [RL10] any byte alignment kept
         default: begin
            sum = {1'b0, off};
         end
      endcase
      // [RL17] carry discarded
      return sum[31:0];
   endfunction : hmag_phys

   assign buf_in_ready = (cnt_reg != 2'd2);
   assign scb_push = (state_reg == hmag_pkg::ST_ISSUE) && (cu_pend_reg || ru_pend_reg);
   assign scb_kind = cu_pend_reg ? hmag_pkg::KIND_CBL_START : hmag_pkg::KIND_RFA_START;
   assign scb_off = gp_reg;
   assign REQ_READY = buf_in_ready && !scb_push;
   assign push_kind = scb_push ? scb_kind : REQ_KIND;
   assign push_off = scb_push ? scb_off : REQ_OFFSET;
   assign push_addr = hmag_phys(push_kind, push_off, cu_base_reg, ru_base_reg);
   assign push = buf_in_ready && (scb_push || REQ_VALID);
   assign pop = (cnt_reg != 2'd0) && ADDR_READY;

   // control block sequencing
   always_comb begin
      state_next = state_reg;
      cu_base_next = cu_base_reg;
      ru_base_next = ru_base_reg;
      gp_next = gp_reg;
      cu_cmd_next = cu_cmd_reg;
      ru_cmd_next = ru_cmd_reg;
      dump_next = dump_reg;
      cu_act_next = cu_act_reg;
      ru_rdy_next = ru_rdy_reg;
      cu_pend_next = cu_pend_reg;
      ru_pend_next = ru_pend_reg;
      cu_post_next = 1'b0;
      ru_post_next = 1'b0;
      irq_next = 1'b0;
      SCB_FETCH = 1'b0;
      SCB_CMD_CLEAR = 1'b0;
      unique case (state_reg)
         hmag_pkg::ST_IDLE: begin
            if (SCB_WRITE) begin
               state_next = hmag_pkg::ST_FETCH;
            end
         end
         hmag_pkg::ST_FETCH: begin
            // [RL12] whole block read on every write seen in ST_IDLE
            SCB_FETCH = 1'b1;
            if (SCB_FETCH_DONE) begin
               cu_cmd_next = SCB_CU_CMD;
               ru_cmd_next = SCB_RU_CMD;
               gp_next = SCB_GEN_PTR;
               state_next = hmag_pkg::ST_ACCEPT;
            end
         end
         hmag_pkg::ST_ACCEPT: begin
            // [RL16] acceptance before action
            SCB_CMD_CLEAR = 1'b1;
            state_next = hmag_pkg::ST_ISSUE;
            unique case (cu_cmd_reg)
               hmag_pkg::CU_START: cu_pend_next = 1'b1;
               hmag_pkg::CU_RESUME: cu_act_next = 1'b1;
               hmag_pkg::CU_LOAD_DUMP_ADDR: dump_next = gp_reg;
               // [RL7] software issues this only when idle
               hmag_pkg::CU_LOAD_BASE: cu_base_next = gp_reg;
               default: cu_act_next = cu_act_reg;
            endcase
            unique case (ru_cmd_reg)
               hmag_pkg::RU_START: ru_pend_next = 1'b1;
               hmag_pkg::RU_LOAD_BASE: ru_base_next = gp_reg;
               default: ru_rdy_next = ru_rdy_reg;
            endcase
         end
         hmag_pkg::ST_ISSUE: begin
            if (!cu_pend_reg && !ru_pend_reg) begin
               state_next = hmag_pkg::ST_IDLE;
            end else if (buf_in_ready) begin
               // [RL13] list start address issued, unit active
               if (cu_pend_reg) begin
                  cu_pend_next = 1'b0;
                  cu_act_next = 1'b1;
               end else begin
                  // [RL14] receive area fetched, unit ready
                  ru_pend_next = 1'b0;
                  ru_rdy_next = 1'b1;
               end
            end
         end
         default: state_next = hmag_pkg::ST_IDLE;
      endcase
      // [RL13] completion posts status and optional interrupt
      if (CU_LIST_DONE && cu_act_reg) begin
         cu_act_next = cu_pend_next;
         cu_post_next = 1'b1;
         irq_next = CU_IRQ_CFG;
      end
      // [RL14] per frame status and interrupt
      if (RU_FRAME_DONE && ru_rdy_reg) begin
         ru_post_next = 1'b1;
         irq_next = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_reg <= hmag_pkg::ST_IDLE;
         cu_base_reg <= hmag_pkg::BASE_RESET;
         ru_base_reg <= hmag_pkg::BASE_RESET;
         gp_reg <= hmag_pkg::PTR_RESET;
         cu_cmd_reg <= hmag_pkg::CU_NOP;
         ru_cmd_reg <= hmag_pkg::RU_NOP;
         dump_reg <= hmag_pkg::PTR_RESET;
         cu_act_reg <= 1'b0;
         ru_rdy_reg <= 1'b0;
         cu_pend_reg <= 1'b0;
         ru_pend_reg <= 1'b0;
         cu_post_reg <= 1'b0;
         ru_post_reg <= 1'b0;
         irq_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cu_base_reg <= cu_base_next;
         ru_base_reg <= ru_base_next;
         gp_reg <= gp_next;
         cu_cmd_reg <= cu_cmd_next;
         ru_cmd_reg <= ru_cmd_next;
         dump_reg <= dump_next;
         cu_act_reg <= cu_act_next;
         ru_rdy_reg <= ru_rdy_next;
         cu_pend_reg <= cu_pend_next;
         ru_pend_reg <= ru_pend_next;
         cu_post_reg <= cu_post_next;
         ru_post_reg <= ru_post_next;
         irq_reg <= irq_next;
      end
   end

   // two-entry address buffer
   always_comb begin
      mem_next[0] = mem_reg[0];
      mem_next[1] = mem_reg[1];
      wptr_next = wptr_reg;
      rptr_next = rptr_reg;
      cnt_next = cnt_reg;
      if (push) begin
         mem_next[wptr_reg] = {push_kind, push_addr};
         wptr_next = !wptr_reg;
      end
      if (pop) begin
         rptr_next = !rptr_reg;
      end
      if (push && !pop) begin
         cnt_next = cnt_reg + 2'd1;
      end else if (pop && !push) begin
         cnt_next = cnt_reg - 2'd1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mem_reg[0] <= 36'h0_0000_0000;
         mem_reg[1] <= 36'h0_0000_0000;
         wptr_reg <= 1'b0;
         rptr_reg <= 1'b0;
         cnt_reg <= 2'd0;
      end else begin
         mem_reg[0] <= mem_next[0];
         mem_reg[1] <= mem_next[1];
         wptr_reg <= wptr_next;
         rptr_reg <= rptr_next;
         cnt_reg <= cnt_next;
      end
   end

   assign ADDR_VALID = (cnt_reg != 2'd0);
   assign ADDR_KIND = mem_reg[rptr_reg][35:32];
   assign ADDR_DATA = mem_reg[rptr_reg][31:0];
   assign CU_STATUS_POST = cu_post_reg;
   assign RU_STATUS_POST = ru_post_reg;
   assign HOST_IRQ = irq_reg;
   assign CU_ACTIVE = cu_act_reg;
   assign RU_READY = ru_rdy_reg;
   assign DUMP_CNT_ADDR = dump_reg;
endmodule : hmag_addr_gen

/* hmag_props.sv */
// assertions on the address generator ports
`timescale 1ns/10ps
module hmag_props (
   // clock and reset
   input wire logic CLK,
   input wire logic ARST_N,
   // control block
   input wire logic SCB_WRITE,
   input wire logic SCB_FETCH_DONE,
   input wire logic SCB_FETCH,
   input wire logic SCB_CMD_CLEAR,
   // unit events
   input wire logic CU_LIST_DONE,
   input wire logic CU_IRQ_CFG,
   input wire logic RU_FRAME_DONE,
   input wire logic CU_STATUS_POST,
   input wire logic RU_STATUS_POST,
   input wire logic HOST_IRQ,
   input wire logic CU_ACTIVE,
   input wire logic RU_READY,
   // address stream
   input wire logic REQ_VALID,
   input wire logic [3:0] REQ_KIND,
   input wire logic [31:0] REQ_OFFSET,
   input wire logic REQ_READY,
   input wire logic ADDR_VALID,
   input wire logic [3:0] ADDR_KIND,
   input wire logic [31:0] ADDR_DATA,
   input wire logic ADDR_READY
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);
   a_fetch_from_write: assert property ($rose(SCB_FETCH) |-> $past(SCB_WRITE))
      else $error("fetch without block write");
   a_fetch_holds: assert property (SCB_FETCH && !SCB_FETCH_DONE |=> SCB_FETCH)
      else $error("fetch dropped early");
   a_clear_after_fetch: assert property (SCB_FETCH && SCB_FETCH_DONE |=> SCB_CMD_CLEAR)
      else $error("no command clear after fetch");
   a_cu_done_posts: assert property (CU_LIST_DONE && CU_ACTIVE && !RU_FRAME_DONE |=>
      CU_STATUS_POST && !CU_ACTIVE && HOST_IRQ == $past(CU_IRQ_CFG))
      else $error("list end not posted");
   a_ru_frame_posts: assert property (RU_FRAME_DONE && RU_READY |=>
      RU_STATUS_POST && HOST_IRQ && RU_READY)
      else $error("frame not posted");
   a_irq_has_cause: assert property (HOST_IRQ |->
      $past(CU_LIST_DONE && CU_ACTIVE && CU_IRQ_CFG || RU_FRAME_DONE && RU_READY))
      else $error("interrupt without cause");
   a_addr_holds: assert property (ADDR_VALID && !ADDR_READY |=>
      ADDR_VALID && $stable(ADDR_DATA) && $stable(ADDR_KIND))
      else $error("address changed while stalled");
   a_absolute_pass: assert property (REQ_VALID && REQ_READY && !ADDR_VALID && REQ_KIND >= 4'h6
      |=> ADDR_VALID && ADDR_KIND == $past(REQ_KIND) && ADDR_DATA == $past(REQ_OFFSET))
      else $error("absolute address altered");
   cover property (SCB_CMD_CLEAR);
   cover property (ADDR_VALID && !ADDR_READY ##1 ADDR_READY);
   cover property (RU_STATUS_POST && HOST_IRQ);
endmodule : hmag_props

bind hmag_addr_gen hmag_props hmag_props_inst (.CLK, .ARST_N, .SCB_WRITE, .SCB_FETCH_DONE,
   .SCB_FETCH, .SCB_CMD_CLEAR, .CU_LIST_DONE, .CU_IRQ_CFG, .RU_FRAME_DONE, .CU_STATUS_POST,
   .RU_STATUS_POST, .HOST_IRQ, .CU_ACTIVE, .RU_READY, .REQ_VALID, .REQ_KIND, .REQ_OFFSET,
   .REQ_READY, .ADDR_VALID, .ADDR_KIND, .ADDR_DATA, .ADDR_READY);

/* hmag_host.sv */
// host side model: control block contents and address sink
`timescale 1ns/10ps
module hmag_host (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // control block read
   input wire logic fetch,
   input wire logic [1:0] lat,
   input wire logic [2:0] cu_in,
   input wire logic [2:0] ru_in,
   input wire logic [31:0] gp_in,
   output logic done,
   output logic [2:0] cu_cmd,
   output logic [2:0] ru_cmd,
   output logic [31:0] gp,
   // address sink
   input wire logic stall,
   output logic addr_ready
);
   logic [1:0] cnt_reg;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) cnt_reg <= 2'h0;
      else cnt_reg <= (fetch && !done) ? cnt_reg + 2'h1 : 2'h0;
   end
   assign done = fetch && cnt_reg == lat;
   // contents are inverted outside the answer cycle so stale values never match
   assign cu_cmd = done ? cu_in : ~cu_in;
   assign ru_cmd = done ? ru_in : ~ru_in;
   assign gp = done ? gp_in : ~gp_in;
   assign addr_ready = !stall;
endmodule : hmag_host

/* testbench.sv */
// self-checking bench for the address generator
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
   $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
   logic CLK = 1'b0, ARST_N = 1'b0, SCB_WRITE = 1'b0, CU_LIST_DONE = 1'b0, CU_IRQ_CFG = 1'b0;
   logic RU_FRAME_DONE = 1'b0, REQ_VALID = 1'b0, stall = 1'b0;
   logic [3:0] REQ_KIND = 4'h0, ADDR_KIND;
   logic [31:0] REQ_OFFSET = 32'h0, host_gp = 32'h0, cu_b = 32'h0, ru_b = 32'h0;
   logic [2:0] host_cu = 3'h0, host_ru = 3'h0, SCB_CU_CMD, SCB_RU_CMD;
   logic [1:0] lat = 2'h1;
   logic SCB_FETCH_DONE, SCB_FETCH, SCB_CMD_CLEAR, CU_STATUS_POST, RU_STATUS_POST, HOST_IRQ;
   logic CU_ACTIVE, RU_READY, REQ_READY, ADDR_VALID, ADDR_READY;
   logic [31:0] SCB_GEN_PTR, DUMP_CNT_ADDR, ADDR_DATA;
   logic [35:0] got[$];
   // each row: kind, offset, expected physical address
   logic [67:0] rows [0:7] = '{
      {4'h2, 32'h0000_1230, 32'h0000_0230},
      {4'h3, 32'h0000_0044, 32'hffff_f044},
      {4'h5, 32'h0000_0f00, 32'hffff_ff00},
      {4'h4, 32'h0000_2040, 32'h0001_2040},
      {4'h6, 32'h8000_0003, 32'h8000_0003},
      {4'h7, 32'h0004_0010, 32'h0004_0010},
      {4'h8, 32'h0000_7770, 32'h0000_7770},
      {4'h2, 32'h0000_1010, 32'h0000_0010}};
   int miscompares = 0, samples_checked = 0, i, n;
   hmag_addr_gen hmag_addr_gen_inst (.CLK, .ARST_N, .SCB_WRITE, .SCB_FETCH_DONE, .SCB_CU_CMD,
      .SCB_RU_CMD, .SCB_GEN_PTR, .SCB_FETCH, .SCB_CMD_CLEAR, .CU_LIST_DONE, .CU_IRQ_CFG,
      .RU_FRAME_DONE, .CU_STATUS_POST, .RU_STATUS_POST, .HOST_IRQ, .CU_ACTIVE, .RU_READY,
      .DUMP_CNT_ADDR, .REQ_VALID, .REQ_KIND, .REQ_OFFSET, .REQ_READY, .ADDR_VALID, .ADDR_KIND,
      .ADDR_DATA, .ADDR_READY);
   hmag_host hmag_host_inst (.clk(CLK), .arst_n(ARST_N), .fetch(SCB_FETCH), .lat(lat),
      .cu_in(host_cu), .ru_in(host_ru), .gp_in(host_gp), .done(SCB_FETCH_DONE),
      .cu_cmd(SCB_CU_CMD), .ru_cmd(SCB_RU_CMD), .gp(SCB_GEN_PTR), .stall(stall),
      .addr_ready(ADDR_READY));
   always #10 CLK = ~CLK;
   always @(posedge CLK) if (ADDR_VALID && ADDR_READY) got.push_back({ADDR_KIND, ADDR_DATA});
   function automatic logic [35:0] expect_of(input logic [35:0] ko);
      logic [31:0] o;
      o = ko[31:0];
      if (ko[35:32] inside {4'h0, 4'h2, 4'h3, 4'h5}) o = cu_b + o;
      else if (ko[35:32] inside {4'h1, 4'h4}) o = ru_b + o;
      return {ko[35:32], o};
   endfunction : expect_of
   task system_control_block(input logic [2:0] c, input logic [2:0] r, input logic [31:0] g);
      host_cu <= c;
      host_ru <= r;
      host_gp <= g;
      SCB_WRITE <= 1'b1;
      @(posedge CLK);
      SCB_WRITE <= 1'b0;
      n = 0;
      while (!SCB_CMD_CLEAR && n < 20) begin @(negedge CLK); n++; end
      `CHK(SCB_CMD_CLEAR, 1'b1)
      repeat (3) @(posedge CLK);
   endtask : system_control_block
   task req(input logic [35:0] ko);
      REQ_VALID <= 1'b1;
      {REQ_KIND, REQ_OFFSET} <= ko;
      n = 0;
      @(negedge CLK);
      while (!REQ_READY && n < 20) begin @(negedge CLK); n++; end
      @(posedge CLK);
   endtask : req
   task take(input logic [35:0] want);
      logic [35:0] v;
      n = 0;
      while (got.size() == 0 && n < 20) begin @(negedge CLK); n++; end
      v = got.size() ? got.pop_front() : 36'hx;
      `CHK(v, want)
      @(posedge CLK);
   endtask : take
   task ev(input logic c, input logic r, input logic q, input logic [4:0] e);
      CU_LIST_DONE <= c;
      RU_FRAME_DONE <= r;
      CU_IRQ_CFG <= q;
      @(posedge CLK);
      CU_LIST_DONE <= 1'b0;
      RU_FRAME_DONE <= 1'b0;
      #1 `CHK({CU_STATUS_POST, RU_STATUS_POST, HOST_IRQ, CU_ACTIVE, RU_READY}, e)
      @(posedge CLK);
   endtask : ev
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   initial begin
      #200000;
      miscompares++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge CLK);
      ARST_N <= 1'b1;
      @(posedge CLK);
      #1 `CHK({SCB_FETCH, ADDR_VALID, CU_ACTIVE, RU_READY, HOST_IRQ, DUMP_CNT_ADDR}, 37'h0)
      @(posedge CLK);
      $display("test reset done");
      cu_b = 32'hffff_f000;
      ru_b = 32'h0001_0000;
      lat <= 2'h2;
      system_control_block(3'h6, 3'h0, cu_b);
      system_control_block(3'h0, 3'h6, ru_b);
      system_control_block(3'h4, 3'h0, 32'h0012_3450);
      `CHK(DUMP_CNT_ADDR, 32'h0012_3450)
      stall <= 1'b1;
      for (i = 0; i < 8; i++) begin
         if (i == 2) begin
            @(negedge CLK);
            `CHK(REQ_READY, 1'b0)
            @(posedge CLK);
            stall <= 1'b0;
         end
         req(rows[i][67:32]);
      end
      REQ_VALID <= 1'b0;
      for (i = 0; i < 8; i++) take({rows[i][67:64], rows[i][31:0]});
      $display("test table done");
      system_control_block(3'h1, 3'h0, 32'h0000_0100);
      take(expect_of({4'h0, 32'h0000_0100}));
      ev(1'b1, 1'b0, 1'b1, 5'b10100);
      system_control_block(3'h1, 3'h1, 32'h0000_0020);
      take(expect_of({4'h0, 32'h0000_0020}));
      take(expect_of({4'h1, 32'h0000_0020}));
      ev(1'b1, 1'b0, 1'b0, 5'b10001);
      ev(1'b0, 1'b1, 1'b0, 5'b01101);
      req({4'h4, 32'h0000_0040});
      REQ_VALID <= 1'b0;
      take(expect_of({4'h4, 32'h0000_0040}));
      system_control_block(3'h2, 3'h0, 32'h0);
      `CHK({CU_ACTIVE, ADDR_VALID}, 2'b10)
      ev(1'b1, 1'b0, 1'b0, 5'b10001);
      $display("test units done");
      ARST_N <= 1'b0;
      repeat (5) @(posedge CLK);
      `CHK({CU_ACTIVE, RU_READY, DUMP_CNT_ADDR}, 34'h0)
      ARST_N <= 1'b1;
      cu_b = 32'h0;
      ru_b = 32'h0;
      @(posedge CLK);
      system_control_block(3'h6, 3'h6, 32'h0);
      req({4'h2, 32'h1234_5678});
      REQ_VALID <= 1'b0;
      take(expect_of({4'h2, 32'h1234_5678}));
      req({4'h7, 32'h0004_0020});
      REQ_VALID <= 1'b0;
      take({4'h7, 32'h0004_0020});
      $display("test linear done");
      final_report();
   end
endmodule : testbench
